// file: tb/baud_rate_generator_assertions.sv
`timescale 1ns/10ps
module brg_checker
(
    input wire logic        clk_i,
    input wire logic        resetn_i,
    input wire logic [7:0]  s_axi_awaddr_i,
    input wire logic        s_axi_awvalid_i,
    input wire logic        s_axi_awready_o,
    input wire logic [31:0] s_axi_wdata_i,
    input wire logic [3:0]  s_axi_wstrb_i,
    input wire logic        s_axi_wvalid_i,
    input wire logic        s_axi_wready_o,
    input wire logic        rate_tick_o,
    input wire logic        clocked_mode_o,
    input wire logic        clock_master_o,
    input wire logic        high_speed_o,
    input wire logic        autobaud_busy_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!resetn_i);

    // Register write taken on both channels
    sequence wr_at(logic [5:0] w);
        s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o
            && s_axi_wstrb_i[0] && s_axi_awaddr_i[7:2] == w;
    endsequence

    tick_gap_a: assert property (rate_tick_o |=> !rate_tick_o [*3])
        else $error("rate tick too soon");
    slave_gate_a: assert property (clocked_mode_o && !clock_master_o |-> !rate_tick_o)
        else $error("tick in clocked slave mode");
    div_clear_a: assert property ((wr_at(6'h01) or wr_at(6'h02)) |-> ##2 !rate_tick_o [*3])
        else $error("tick soon after divisor write");
    mode_bit_a: assert property (wr_at(6'h03) |-> ##2 clocked_mode_o == $past(s_axi_wdata_i[4], 2))
        else $error("clocked mode not from bit 4");
    speed_bit_a: assert property (wr_at(6'h03) |-> ##2 high_speed_o == $past(s_axi_wdata_i[2], 2))
        else $error("high speed not from bit 2");
    master_bit_a: assert property (wr_at(6'h03) |-> ##2 clock_master_o ==
        ($past(s_axi_wdata_i[7], 2) && $past(s_axi_wdata_i[4], 2))) else $error("master wrong");
    ab_start_a: assert property (wr_at(6'h00) ##0 (s_axi_wdata_i[0] && !clocked_mode_o)
        |-> ##[2:3] autobaud_busy_o) else $error("auto-baud did not start");
    ab_hold_a: assert property (autobaud_busy_o && $past(autobaud_busy_o) |-> !rate_tick_o)
        else $error("tick during auto-baud");
endmodule

// file: tb/serial_partner.sv
`timescale 1ns/10ps
module serial_partner
(
    input  wire logic clk_i,
    output logic      rx_o,
    output logic      rx_active_o
);
    initial
    begin
        rx_o        = 1'b1;
        rx_active_o = 1'b0;
    end

    // Start bit, eight data bits lsb first, stop bit
    task automatic send(input logic [7:0] b, input int bit_clks);
        logic [9:0] f;
        f = {1'b1, b, 1'b0};
        rx_active_o <= 1'b1;
        for (int i = 0; i < 10; i++)
        begin
            rx_o <= f[i];
            repeat (bit_clks) @(posedge clk_i);
        end
        rx_active_o <= 1'b0;
    endtask
endmodule

// file: tb/tb_baud_rate_generator.sv
`timescale 1ns/10ps
module tb_baud_rate_generator;
    logic        clk_i = 1'b0;
    logic        resetn_i = 1'b0;
    logic [7:0]  awaddr = 8'h00;
    logic [7:0]  araddr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic        awv = 1'b0;
    logic        wv = 1'b0;
    logic        arv = 1'b0;
    logic        awr, wr, bv, arr, rv, rx, ract, tick, irq, pol;
    logic [1:0]  rresp, bresp;
    logic [31:0] rdata;
    int          bad_count = 0;
    int          total_checks = 0;
    int          p;
    logic [7:0]  tx_t [5] = '{8'h00, 8'h04, 8'h00, 8'h94, 8'h10};
    logic [7:0]  ct_t [5] = '{8'h00, 8'h00, 8'h08, 8'h00, 8'h00};
    int          pe_t [5] = '{192, 48, 4144, 12, 0};

    always #10 clk_i = ~clk_i;

    baud_rate_generator baud_rate_generator_i
    (
        .clk_i(clk_i), .resetn_i(resetn_i), .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awv),
        .s_axi_awready_o(awr), .s_axi_wdata_i(wdata), .s_axi_wstrb_i(4'hf),
        .s_axi_wvalid_i(wv), .s_axi_wready_o(wr), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bv),
        .s_axi_bready_i(1'b1), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arv),
        .s_axi_arready_o(arr), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
        .s_axi_rvalid_o(rv), .s_axi_rready_i(1'b1), .rx_i(rx), .rx_active_i(ract),
        .rate_tick_o(tick), .clocked_mode_o(), .clock_master_o(), .high_speed_o(),
        .serial_clock_polarity_o(pol), .autobaud_busy_o(), .irq_o(irq)
    );

    serial_partner serial_partner_i (.clk_i(clk_i), .rx_o(rx), .rx_active_o(ract));

    task automatic final_report();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // One register access; valids drop once taken, answer ends it
    task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
        int i;
        awaddr <= a;
        araddr <= a;
        wdata  <= d;
        awv    <= w;
        wv     <= w;
        arv    <= !w;
        for (i = 0; i < 50; i++)
        begin
            @(posedge clk_i);
            if (bv || rv)
                break;
            awv <= awv && !awr;
            wv  <= wv && !wr;
            arv <= arv && !arr;
        end
        if (i == 50)
        begin
            bad_count++;
            final_report();
        end
    endtask

    task automatic rc(input string nm, input logic [7:0] a, input logic [31:0] e);
        acc(1'b0, a, 32'h0);
        chk(nm, rdata, e);
    endtask

    // Cycles between two ticks, zero when none come
    task automatic period(output int q);
        int i;
        q = 0;
        for (i = 0; i < 20000; i++)
        begin
            @(posedge clk_i);
            if (tick && q > 0)
                break;
            if (tick || q > 0)
                q++;
        end
        if (i == 20000)
            q = 0;
    endtask

    initial
    begin
        repeat (2) @(posedge clk_i);
        resetn_i <= 1'b1;
        rc("control", 8'h00, 32'h40);
        rc("divisor high", 8'h08, 32'h0);
        rc("tx control", 8'h0c, 32'h0);
        for (int k = 0; k < 5; k++)
        begin
            acc(1'b1, 8'h0c, {24'h0, tx_t[k]});
            acc(1'b1, 8'h00, {24'h0, ct_t[k]});
            acc(1'b1, 8'h08, 32'h1);
            acc(1'b1, 8'h04, 32'h2);
            period(p);
            chk("tick period", p, pe_t[k]);
        end
        acc(1'b1, 8'h00, 32'hb0);
        chk("polarity", pol, 1);
        rc("control", 8'h00, 32'h50);
        acc(1'b1, 8'h0c, 32'h0);
        acc(1'b1, 8'h00, 32'h1);
        serial_partner_i.send(8'h55, 272);
        rc("divisor low", 8'h04, 32'h3);
        rc("control", 8'h00, 32'h40);
        chk("irq masked", irq, 0);
        acc(1'b1, 8'h14, 32'h2);
        chk("irq", irq, 1);
        rc("irq status", 8'h10, 32'h2);
        acc(1'b1, 8'h10, 32'h2);
        chk("irq cleared", irq, 0);
        acc(1'b1, 8'h14, 32'h1);
        acc(1'b1, 8'h00, 32'h2);
        serial_partner_i.send(8'hff, 20);
        chk("wake irq", irq, 1);
        rc("control", 8'h00, 32'h40);
        acc(1'b1, 8'h10, 32'h1);
        chk("wake cleared", irq, 0);
        chk("write resp", bresp, 0);
        acc(1'b1, 8'h40, 32'h1);
        chk("unmapped write resp", bresp, 2);
        rc("unmapped", 8'h40, 32'h0);
        chk("read resp", rresp, 2);
        final_report();
    end
endmodule

bind baud_rate_generator brg_checker brg_checker_i (.*);

// file: verilog/baud_rate_generator.sv
`timescale 1ns/10ps
`include "rate_gen_map.svh"
module baud_rate_generator
    import rate_gen_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        resetn_i,
    input  wire logic [7:0]  s_axi_awaddr_i,
    input  wire logic        s_axi_awvalid_i,
    output logic             s_axi_awready_o,
    input  wire logic [31:0] s_axi_wdata_i,
    input  wire logic [3:0]  s_axi_wstrb_i,
    input  wire logic        s_axi_wvalid_i,
    output logic             s_axi_wready_o,
    output logic [1:0]       s_axi_bresp_o,
    output logic             s_axi_bvalid_o,
    input  wire logic        s_axi_bready_i,
    input  wire logic [7:0]  s_axi_araddr_i,
    input  wire logic        s_axi_arvalid_i,
    output logic             s_axi_arready_o,
    output logic [31:0]      s_axi_rdata_o,
    output logic [1:0]       s_axi_rresp_o,
    output logic             s_axi_rvalid_o,
    input  wire logic        s_axi_rready_i,
    input  wire logic        rx_i,
    input  wire logic        rx_active_i,
    output logic             rate_tick_o,
    output logic             clocked_mode_o,
    output logic             clock_master_o,
    output logic             high_speed_o,
    output logic             serial_clock_polarity_o,
    output logic             autobaud_busy_o,
    output logic             irq_o
);
    import rate_gen_pkg::*;

    regbus_if bus ();

    // Software-visible state
    logic            rollover_q;
    logic            polarity_q;
    logic            wide_q;
    logic            wake_en_q;
    logic            ab_en_q;
    logic [7:0]      div_lo_q;
    logic [7:0]      div_hi_q;
    logic            master_q;
    logic            clocked_q;
    logic            hispeed_q;
    logic [2:0]      irq_stat_q;
    logic [2:0]      irq_mask_q;

    // Receive line synchroniser
    logic            rx_meta_q;
    logic            rx_sync_q;
    logic            rx_prev_q;
    logic            rx_fall;
    logic            rx_rise;

    // Auto-baud measurement
    autobaud_state_t ab_state_q;
    logic [8:0]      ab_pre_q;
    logic [8:0]      ab_pre_last;
    logic [15:0]     ab_cnt_q;
    logic [2:0]      ab_edges_q;
    logic            ab_done;
    logic            ab_roll;
    logic [15:0]     ab_result;

    // Wake-on-edge
    logic            wake_armed_q;
    logic            wake_fall;
    logic            wake_clear;

    // Decode
    logic            wr_ctrl;
    logic            wr_lo;
    logic            wr_hi;
    logic            wr_tx;
    logic            wr_stat;
    logic            wr_mask;
    logic [2:0]      irq_set;
    prescale_t       prescale;
    logic            timer_clear;
    logic            timer_tick;

    function automatic logic map_hit(input logic [7:0] addr);
        case (addr)
            `RG_OFS_CTRL, `RG_OFS_DIV_LO, `RG_OFS_DIV_HI,
            `RG_OFS_TXCTRL, `RG_OFS_IRQ_STAT, `RG_OFS_IRQ_MASK:
                map_hit = 1'b1;
            default:
                map_hit = 1'b0;
        endcase
    endfunction

    function automatic logic wr_hit(input logic stb, input logic [7:0] addr,
                                    input logic [7:0] ofs);
        wr_hit = stb && (addr == ofs);
    endfunction

    rate_axil_slave u_slave (
        .clk_i           (clk_i),
        .resetn_i        (resetn_i),
        .s_axi_awaddr_i  (s_axi_awaddr_i),
        .s_axi_awvalid_i (s_axi_awvalid_i),
        .s_axi_awready_o (s_axi_awready_o),
        .s_axi_wdata_i   (s_axi_wdata_i),
        .s_axi_wstrb_i   (s_axi_wstrb_i),
        .s_axi_wvalid_i  (s_axi_wvalid_i),
        .s_axi_wready_o  (s_axi_wready_o),
        .s_axi_bresp_o   (s_axi_bresp_o),
        .s_axi_bvalid_o  (s_axi_bvalid_o),
        .s_axi_bready_i  (s_axi_bready_i),
        .s_axi_araddr_i  (s_axi_araddr_i),
        .s_axi_arvalid_i (s_axi_arvalid_i),
        .s_axi_arready_o (s_axi_arready_o),
        .s_axi_rdata_o   (s_axi_rdata_o),
        .s_axi_rresp_o   (s_axi_rresp_o),
        .s_axi_rvalid_o  (s_axi_rvalid_o),
        .s_axi_rready_i  (s_axi_rready_i),
        .bus             (bus.slave)
    );

    assign wr_ctrl = wr_hit(bus.wr_stb, bus.wr_addr, `RG_OFS_CTRL);
    assign wr_lo   = wr_hit(bus.wr_stb, bus.wr_addr, `RG_OFS_DIV_LO);
    assign wr_hi   = wr_hit(bus.wr_stb, bus.wr_addr, `RG_OFS_DIV_HI);
    assign wr_tx   = wr_hit(bus.wr_stb, bus.wr_addr, `RG_OFS_TXCTRL);
    assign wr_stat = wr_hit(bus.wr_stb, bus.wr_addr, `RG_OFS_IRQ_STAT);
    assign wr_mask = wr_hit(bus.wr_stb, bus.wr_addr, `RG_OFS_IRQ_MASK);
    assign bus.wr_err = !map_hit(bus.wr_addr);
    assign bus.rd_err = !map_hit(bus.rd_addr);

    // One generator for both modes; high speed ignored when clocked
    assign prescale = prescale_of(clocked_q, wide_q, hispeed_q);

    // Held cleared while auto-baud owns the divisor
    assign timer_clear = wr_lo || wr_hi || ab_done || (ab_state_q != AB_IDLE);

    rate_timer u_timer (
        .clk_i      (clk_i),
        .resetn_i   (resetn_i),
        .clear_i    (timer_clear),
        .wide_i     (wide_q),
        .prescale_i (prescale),
        .divisor_i  ({div_hi_q, div_lo_q}),
        .tick_o     (timer_tick)
    );

    // Clocked slave takes its clock from outside
    assign rate_tick_o             = timer_tick && (!clocked_q || master_q);
    assign clocked_mode_o          = clocked_q;
    assign clock_master_o          = clocked_q && master_q;
    assign high_speed_o            = hispeed_q;
    assign serial_clock_polarity_o = polarity_q;
    assign autobaud_busy_o         = ab_state_q != AB_IDLE;

    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            rx_meta_q <= 1'b1;
            rx_sync_q <= 1'b1;
            rx_prev_q <= 1'b1;
        end
        else
        begin
            rx_meta_q <= rx_i;
            rx_sync_q <= rx_meta_q;
            rx_prev_q <= rx_sync_q;
        end
    end

    assign rx_fall = rx_prev_q && !rx_sync_q;
    assign rx_rise = !rx_prev_q && rx_sync_q;

    // Auto-baud: count eight bit times from start edge to fifth falling edge
    assign ab_pre_last = (prescale == PRE_64) ? `RG_AB_LAST_64 : `RG_AB_LAST_16;
    // Edges counted before this one, so the last edge is one short of the total
    assign ab_done     = (ab_state_q == AB_MEASURE) && rx_fall
                         && (ab_edges_q == `RG_AB_EDGES - 3'd1);
    assign ab_roll     = (ab_state_q == AB_MEASURE) && (ab_pre_q == ab_pre_last)
                         && (ab_cnt_q == 16'hffff);
    assign ab_result   = ab_cnt_q - 16'h0001;

    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            ab_state_q <= AB_IDLE;
            ab_pre_q   <= 9'h000;
            ab_cnt_q   <= 16'h0000;
            ab_edges_q <= 3'h0;
        end
        else
        begin
            case (ab_state_q)
                AB_IDLE:
                    if (ab_en_q && !clocked_q)
                        ab_state_q <= AB_WAIT_START;
                AB_WAIT_START:
                    if (!ab_en_q || clocked_q)
                        ab_state_q <= AB_IDLE;
                    else if (rx_fall)
                    begin
                        ab_state_q <= AB_MEASURE;
                        ab_pre_q   <= 9'h000;
                        ab_cnt_q   <= 16'h0000;
                        ab_edges_q <= 3'h0;
                    end
                AB_MEASURE:
                    if (!ab_en_q || clocked_q || ab_done)
                        ab_state_q <= AB_IDLE;
                    else
                    begin
                        if (rx_fall)
                            ab_edges_q <= ab_edges_q + 3'h1;
                        if (ab_pre_q == ab_pre_last)
                        begin
                            ab_pre_q <= 9'h000;
                            ab_cnt_q <= ab_cnt_q + 16'h0001;
                        end
                        else
                            ab_pre_q <= ab_pre_q + 9'h001;
                    end
                default:
                    ab_state_q <= AB_IDLE;
            endcase
        end
    end

    // Wake-on-edge, asynchronous mode only
    assign wake_fall  = wake_en_q && !clocked_q && rx_fall;
    assign wake_clear = wake_armed_q && rx_rise;

    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
            wake_armed_q <= 1'b0;
        else if (!wake_en_q || clocked_q || wake_clear)
            wake_armed_q <= 1'b0;
        else if (wake_fall)
            wake_armed_q <= 1'b1;
    end

    // Control register; hardware set of rollover wins over software clear
    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            rollover_q <= 1'(`RG_CTRL_RESET >> `RG_CTRL_ROLLOVER);
            polarity_q <= 1'b0;
            wide_q     <= 1'b0;
            wake_en_q  <= 1'b0;
            ab_en_q    <= 1'b0;
        end
        else
        begin
            if (ab_roll)
                rollover_q <= 1'b1;
            else if (wr_ctrl && !bus.wr_data[`RG_CTRL_ROLLOVER])
                rollover_q <= 1'b0;
            if (wr_ctrl)
            begin
                polarity_q <= bus.wr_data[`RG_CTRL_POLARITY];
                wide_q     <= bus.wr_data[`RG_CTRL_WIDE];
            end
            if (wr_ctrl)
                wake_en_q <= bus.wr_data[`RG_CTRL_WAKE];
            else if (wake_clear)
                wake_en_q <= 1'b0;
            if (wr_ctrl)
                ab_en_q <= bus.wr_data[`RG_CTRL_AUTOBAUD];
            else if (ab_done)
                ab_en_q <= 1'b0;
        end
    end

    // Divisor bytes, loaded by software or by a finished measurement
    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            div_lo_q <= `RG_DIV_RESET;
            div_hi_q <= `RG_DIV_RESET;
        end
        else if (ab_done)
        begin
            div_lo_q <= ab_result[7:0];
            if (wide_q)
                div_hi_q <= ab_result[15:8];
        end
        else
        begin
            if (wr_lo)
                div_lo_q <= bus.wr_data;
            if (wr_hi)
                div_hi_q <= bus.wr_data;
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            master_q  <= 1'b0;
            clocked_q <= 1'b0;
            hispeed_q <= 1'b0;
        end
        else if (wr_tx)
        begin
            master_q  <= bus.wr_data[`RG_TX_MASTER];
            clocked_q <= bus.wr_data[`RG_TX_CLOCKED];
            hispeed_q <= bus.wr_data[`RG_TX_HISPEED];
        end
    end

    // Sticky interrupt status; a new event beats a write-one clear
    assign irq_set[`RG_IRQ_WAKE]     = wake_fall;
    assign irq_set[`RG_IRQ_AB_DONE]  = ab_done;
    assign irq_set[`RG_IRQ_ROLLOVER] = ab_roll;

    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            irq_stat_q <= 3'h0;
            irq_mask_q <= 3'h0;
        end
        else
        begin
            if (wr_stat)
                irq_stat_q <= (irq_stat_q & ~bus.wr_data[2:0]) | irq_set;
            else
                irq_stat_q <= irq_stat_q | irq_set;
            if (wr_mask)
                irq_mask_q <= bus.wr_data[2:0];
        end
    end

    assign irq_o = |(irq_stat_q & irq_mask_q);

    always_comb
    begin
        case (bus.rd_addr)
            `RG_OFS_CTRL:
                bus.rd_data = {rollover_q, !rx_active_i && (ab_state_q == AB_IDLE),
                               1'b0, polarity_q, wide_q, 1'b0, wake_en_q, ab_en_q};
            `RG_OFS_DIV_LO:   bus.rd_data = div_lo_q;
            `RG_OFS_DIV_HI:   bus.rd_data = div_hi_q;
            `RG_OFS_TXCTRL:
                bus.rd_data = {master_q, 2'b00, clocked_q, 1'b0, hispeed_q, 2'b00};
            `RG_OFS_IRQ_STAT: bus.rd_data = {5'h00, irq_stat_q};
            `RG_OFS_IRQ_MASK: bus.rd_data = {5'h00, irq_mask_q};
            default:          bus.rd_data = 8'h00;
        endcase
    end
endmodule

// file: verilog/rate_axil_slave.sv
`timescale 1ns/10ps
module rate_axil_slave
(
    input  wire logic       clk_i,
    input  wire logic       resetn_i,
    input  wire logic [7:0] s_axi_awaddr_i,
    input  wire logic       s_axi_awvalid_i,
    output logic            s_axi_awready_o,
    input  wire logic [31:0] s_axi_wdata_i,
    input  wire logic [3:0] s_axi_wstrb_i,
    input  wire logic       s_axi_wvalid_i,
    output logic            s_axi_wready_o,
    output logic [1:0]      s_axi_bresp_o,
    output logic            s_axi_bvalid_o,
    input  wire logic       s_axi_bready_i,
    input  wire logic [7:0] s_axi_araddr_i,
    input  wire logic       s_axi_arvalid_i,
    output logic            s_axi_arready_o,
    output logic [31:0]     s_axi_rdata_o,
    output logic [1:0]      s_axi_rresp_o,
    output logic            s_axi_rvalid_o,
    input  wire logic       s_axi_rready_i,
    regbus_if.slave         bus
);
    logic       aw_full_q;
    logic [7:0] aw_addr_q;
    logic       w_full_q;
    logic [7:0] w_data_q;
    logic       w_lane0_q;
    logic       do_wr;

    assign s_axi_awready_o = !aw_full_q && !s_axi_bvalid_o;
    assign s_axi_wready_o  = !w_full_q && !s_axi_bvalid_o;
    assign s_axi_arready_o = !s_axi_rvalid_o;
    assign do_wr           = aw_full_q && w_full_q && !s_axi_bvalid_o;
    assign bus.wr_stb      = do_wr && w_lane0_q;
    assign bus.wr_addr     = aw_addr_q;
    assign bus.wr_data     = w_data_q;
    assign bus.rd_addr     = s_axi_araddr_i;

    // Address and data accepted in either order
    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            aw_full_q <= 1'b0;
            aw_addr_q <= 8'h00;
            w_full_q  <= 1'b0;
            w_data_q  <= 8'h00;
            w_lane0_q <= 1'b0;
        end
        else if (do_wr)
        begin
            aw_full_q <= 1'b0;
            w_full_q  <= 1'b0;
        end
        else
        begin
            if (s_axi_awvalid_i && s_axi_awready_o)
            begin
                aw_full_q <= 1'b1;
                aw_addr_q <= {s_axi_awaddr_i[7:2], 2'b00};
            end
            if (s_axi_wvalid_i && s_axi_wready_o)
            begin
                w_full_q  <= 1'b1;
                w_data_q  <= s_axi_wdata_i[7:0];
                w_lane0_q <= s_axi_wstrb_i[0];
            end
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            s_axi_bvalid_o <= 1'b0;
            s_axi_bresp_o  <= 2'b00;
        end
        else if (do_wr)
        begin
            s_axi_bvalid_o <= 1'b1;
            s_axi_bresp_o  <= bus.wr_err ? 2'b10 : 2'b00;
        end
        else if (s_axi_bready_i)
            s_axi_bvalid_o <= 1'b0;
    end

    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            s_axi_rvalid_o <= 1'b0;
            s_axi_rdata_o  <= 32'h0000_0000;
            s_axi_rresp_o  <= 2'b00;
        end
        else if (s_axi_arvalid_i && s_axi_arready_o)
        begin
            s_axi_rvalid_o <= 1'b1;
            s_axi_rdata_o  <= {24'h00_0000, bus.rd_data};
            s_axi_rresp_o  <= bus.rd_err ? 2'b10 : 2'b00;
        end
        else if (s_axi_rready_i)
            s_axi_rvalid_o <= 1'b0;
    end
endmodule

// file: verilog/rate_gen_map.svh
// Contract
// - Divider is 8 bits after reset; wide select uses both divisor bytes.
// - One rate generator serves both asynchronous and clocked modes.
// - Divisor bytes set period of a free-running timer; each overflow ticks.
// - Asynchronous rate depends on high-speed select, wide select and divisor.
// - Clocked mode ignores high-speed select; wide select and divisor still apply.
// - Clocked mode: divisor rate drives serial clock only as master.
// - Writing either divisor byte clears the rate timer at once.
// - Rollover during auto-baud sets flag; only software clears it, writing zero.
// - Rate is clock/64(n+1), /16(n+1) high speed or wide, /4(n+1) clocked.
// - Clocked-mode select is bit 4 of transmit control; one means clocked.
// - Asynchronous high-speed select: one high-speed division, zero low-speed.
// - Clock source master select one in clocked mode: clock generated internally.
`ifndef RATE_GEN_MAP_SVH
`define RATE_GEN_MAP_SVH

// Register byte offsets
`define RG_OFS_CTRL      8'h00
`define RG_OFS_DIV_LO    8'h04
`define RG_OFS_DIV_HI    8'h08
`define RG_OFS_TXCTRL    8'h0c
`define RG_OFS_IRQ_STAT  8'h10
`define RG_OFS_IRQ_MASK  8'h14

// Rate generator control fields
`define RG_CTRL_ROLLOVER 7
`define RG_CTRL_RXIDLE   6
`define RG_CTRL_POLARITY 4
`define RG_CTRL_WIDE     3
`define RG_CTRL_WAKE     1
`define RG_CTRL_AUTOBAUD 0

// Transmit control fields
`define RG_TX_MASTER     7
`define RG_TX_CLOCKED    4
`define RG_TX_HISPEED    2

// Interrupt status and mask fields
`define RG_IRQ_WAKE      0
`define RG_IRQ_AB_DONE   1
`define RG_IRQ_ROLLOVER  2

// Reset values
`define RG_CTRL_RESET    8'h00
`define RG_DIV_RESET     8'h00
`define RG_TXCTRL_RESET  8'h00

// Prescale lengths minus one, per divide class
`define RG_PRE_LAST_64   6'd63
`define RG_PRE_LAST_16   6'd15
`define RG_PRE_LAST_4    6'd3

// Auto-baud measuring prescale: eight rate prescale periods per count, minus one
`define RG_AB_LAST_64    9'd511
`define RG_AB_LAST_16    9'd127
// Falling edges after the start bit in a 55h character
`define RG_AB_EDGES      3'd4

`endif

// file: verilog/rate_gen_pkg.sv
package rate_gen_pkg;

    typedef enum logic [1:0] {PRE_64, PRE_16, PRE_4} prescale_t;

    typedef enum {AB_IDLE, AB_WAIT_START, AB_MEASURE} autobaud_state_t;

    // Divide class from mode bits
    function automatic prescale_t prescale_of(input logic clocked, input logic wide,
                                              input logic hispeed);
        if (clocked)
            return PRE_4;
        else if (wide || hispeed)
            return PRE_16;
        else
            return PRE_64;
    endfunction

endpackage

// file: verilog/rate_timer.sv
`timescale 1ns/10ps
`include "rate_gen_map.svh"
module rate_timer
    import rate_gen_pkg::*;
(
    input  wire logic                    clk_i,
    input  wire logic                    resetn_i,
    input  wire logic                    clear_i,
    input  wire logic                    wide_i,
    input  wire rate_gen_pkg::prescale_t prescale_i,
    input  wire logic [15:0]             divisor_i,
    output logic                         tick_o
);
    import rate_gen_pkg::*;

    logic [5:0]  pre_q;
    logic [5:0]  pre_last;
    logic [15:0] cnt_q;
    logic [15:0] top;

    always_comb
    begin
        case (prescale_i)
            PRE_64:  pre_last = `RG_PRE_LAST_64;
            PRE_16:  pre_last = `RG_PRE_LAST_16;
            PRE_4:   pre_last = `RG_PRE_LAST_4;
            default: pre_last = `RG_PRE_LAST_64;
        endcase
    end

    // High byte ignored in 8-bit mode
    assign top = wide_i ? divisor_i : {8'h00, divisor_i[7:0]};

    // Period is prescale times (n+1), free running
    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            pre_q  <= 6'h00;
            cnt_q  <= 16'h0000;
            tick_o <= 1'b0;
        end
        else if (clear_i)
        begin
            pre_q  <= 6'h00;
            cnt_q  <= 16'h0000;
            tick_o <= 1'b0;
        end
        else
        begin
            tick_o <= 1'b0;
            if (pre_q >= pre_last)
            begin
                pre_q <= 6'h00;
                if (cnt_q >= top)
                begin
                    cnt_q  <= 16'h0000;
                    tick_o <= 1'b1;
                end
                else
                    cnt_q <= cnt_q + 16'h0001;
            end
            else
                pre_q <= pre_q + 6'h01;
        end
    end
endmodule

// file: verilog/regbus_if.sv
`timescale 1ns/10ps
interface regbus_if;
    logic       wr_stb;
    logic [7:0] wr_addr;
    logic [7:0] wr_data;
    logic       wr_err;
    logic [7:0] rd_addr;
    logic [7:0] rd_data;
    logic       rd_err;

    modport slave (output wr_stb, wr_addr, wr_data, rd_addr,
                   input  wr_err, rd_data, rd_err);
    modport core  (input  wr_stb, wr_addr, wr_data, rd_addr,
                   output wr_err, rd_data, rd_err);
endinterface
